// >>> shared/arg_pkg.sv
// Package for the converter reference and ground select block
package arg_pkg;
  // Special-function register addresses
  localparam logic [7:0] TEMP_OFFSET_LOW_ADDR = 8'h85;
  localparam logic [7:0] TEMP_OFFSET_HIGH_ADDR = 8'h86;
  localparam logic [7:0] REFERENCE_CONTROL_ADDR = 8'hd1;
  // Field positions in the reference control register
  localparam int GND_SEL_BIT = 5;
  localparam int REF_SEL_HI = 4;
  localparam int REF_SEL_LO = 3;
  localparam int TEMP_EN_BIT = 2;
  localparam int REF_OE_BIT = 0;
  // Offset low byte layout
  localparam int OFFSET_LOW_HI = 7;
  localparam int OFFSET_LOW_LO = 6;
  // Reset values
  localparam logic [1:0] REF_SEL_RESET = 2'h3;
  localparam logic GND_SEL_RESET = 1'b0;
  localparam logic TEMP_EN_RESET = 1'b0;
  localparam logic REF_OE_RESET = 1'b0;
  // Reference select codes
  localparam logic [1:0] REF_EXTERNAL = 2'h0;
  localparam logic [1:0] REF_MAIN_SUPPLY = 2'h1;
  localparam logic [1:0] REF_DIGITAL_SUPPLY = 2'h2;
  localparam logic [1:0] REF_HIGH_SPEED = 2'h3;
  // Voltage reference source to the analog mux
  typedef enum logic [2:0] {
    ARG_SRC_EXT_PIN,
    ARG_SRC_PRECISION,
    ARG_SRC_MAIN_SUPPLY,
    ARG_SRC_DIGITAL_SUPPLY,
    ARG_SRC_HIGH_SPEED
  } arg_ref_src_t;
  // Ground source to the analog mux
  typedef enum logic [1:0] {
    ARG_GND_PIN,
    ARG_GND_ANALOG_PIN,
    ARG_GND_INTERNAL
  } arg_gnd_src_t;
  // Converter phase tracking
  typedef enum logic [1:0] {
    ARG_IDLE,
    ARG_SAMPLE,
    ARG_CONVERT
  } arg_phase_t;
endpackage : arg_pkg

// >>> rtl/arg_ref_select.sv
// Converter voltage and ground reference selection with offset registers
// Functional notes
// R1 - Offset high byte returns offset bits 9:2
// R2 - Offset low byte: bits 1:0 on top
// R3 - External reference: select 00, output enable 0
// R4 - Select 11: high-speed reference, automatic
// R5 - High-speed reference low power when idle
// R6 - Output enable with 00: precision, drive pin
// R7 - 01 main supply, 10 digital supply
// R8 - Ground select picks analog ground pin
// R9 - Sensor sampling always uses internal ground
// R10 - High-speed reference converts on internal ground
// R11 - Sensor disabled: output high impedance
// R12 - Enable precision reference before precision oscillator
// R13 - Control register field layout, unused read zero
// R14 - Settings apply from next sampling phase; output enable and sensor enable bits, and the select for the pin drive, act at once here
`timescale 1ns/1ps
module arg_ref_select
  import arg_pkg::*;
(
  // Clock, reset and clock enable
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  // Register port from the core
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  // Factory offset from production trim
  input wire logic [9:0] TEMP_OFFSET_VALUE,
  // Converter phase indications
  input wire logic SAMPLE_ACTIVE,
  input wire logic CONVERT_ACTIVE,
  input wire logic SENSOR_CHANNEL,
  // Analog control outputs
  output arg_pkg::arg_ref_src_t REF_SOURCE,
  output arg_pkg::arg_gnd_src_t GND_SOURCE,
  output logic HS_REF_ENABLE,
  output logic PRECISION_REF_ENABLE,
  output logic EXTERNAL_REF_PIN_DRIVE,
  output logic TEMP_SENSOR_ENABLE,
  output logic TEMP_SENSOR_HIZ
);
  import arg_pkg::*;

  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic gnd_sel;
    logic [1:0] ref_sel;
    logic temp_en;
    logic ref_oe;
    logic act_gnd_sel;
    logic [1:0] act_ref_sel;
    logic act_sensor;
    arg_phase_t phase;
  } arg_state_t;

  arg_state_t st_ff;
  arg_state_t nxt_st;
  logic rst_n;
  logic ctrl_wr;

  assign rst_n = st_ff.rst_sync;
  assign ctrl_wr = SFR_WR && (SFR_ADDR == REFERENCE_CONTROL_ADDR);

  // Next state: register writes, phase tracking and latched settings
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rst_meta = 1'b1;
    nxt_st.rst_sync = st_ff.rst_meta;
    if (ctrl_wr)
    begin
      // Unused bits are simply not stored
      nxt_st.gnd_sel = SFR_WDATA[GND_SEL_BIT]; // R13
      nxt_st.ref_sel = SFR_WDATA[REF_SEL_HI:REF_SEL_LO]; // R13
      nxt_st.temp_en = SFR_WDATA[TEMP_EN_BIT]; // R13
      nxt_st.ref_oe = SFR_WDATA[REF_OE_BIT]; // R13
    end
    // Select and ground settings latch only on entry to sampling, so a write mid-convert
    // cannot move them; the output enable bit, and the select as used for the pin drive, still act on the next cycle
    if (SAMPLE_ACTIVE && st_ff.phase != ARG_SAMPLE)
    begin
      nxt_st.act_gnd_sel = st_ff.gnd_sel; // R14
      nxt_st.act_ref_sel = st_ff.ref_sel; // R14
      nxt_st.act_sensor = SENSOR_CHANNEL;
    end
    if (SAMPLE_ACTIVE)
      nxt_st.phase = ARG_SAMPLE;
    else if (CONVERT_ACTIVE)
      nxt_st.phase = ARG_CONVERT;
    else
      nxt_st.phase = ARG_IDLE;
  end

  // State register; reset synchroniser sits in the same struct
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_ff <= '0;
      st_ff.ref_sel <= REF_SEL_RESET;
      st_ff.gnd_sel <= GND_SEL_RESET;
      st_ff.temp_en <= TEMP_EN_RESET;
      st_ff.ref_oe <= REF_OE_RESET;
      st_ff.act_ref_sel <= REF_SEL_RESET;
      st_ff.phase <= ARG_IDLE;
    end
    else if (CLK_EN)
    begin
      // Clock enable freezes the synchroniser as well as the settings
      if (!st_ff.rst_sync)
      begin
        // Hold control state while the released reset propagates
        st_ff.rst_meta <= 1'b1;
        st_ff.rst_sync <= st_ff.rst_meta;
      end
      else
        st_ff <= nxt_st;
    end
  end

  // Register reads; offset bytes come straight from trim
  always_comb
  begin
    SFR_RDATA = 8'h00;
    unique case (SFR_ADDR)
      TEMP_OFFSET_HIGH_ADDR: SFR_RDATA = TEMP_OFFSET_VALUE[9:2]; // R1
      TEMP_OFFSET_LOW_ADDR:
        SFR_RDATA[OFFSET_LOW_HI:OFFSET_LOW_LO] = TEMP_OFFSET_VALUE[1:0]; // R2
      REFERENCE_CONTROL_ADDR:
      begin
        SFR_RDATA[GND_SEL_BIT] = st_ff.gnd_sel; // R13
        SFR_RDATA[REF_SEL_HI:REF_SEL_LO] = st_ff.ref_sel; // R13
        SFR_RDATA[TEMP_EN_BIT] = st_ff.temp_en; // R13
        SFR_RDATA[REF_OE_BIT] = st_ff.ref_oe; // R13
      end
      default: SFR_RDATA = 8'h00;
    endcase
  end

  // Reference source from the select latched for this conversion and the live output enable bit
  always_comb
  begin
    unique case (st_ff.act_ref_sel)
      REF_EXTERNAL:
        REF_SOURCE = st_ff.ref_oe ? ARG_SRC_PRECISION : ARG_SRC_EXT_PIN; // R6
      REF_MAIN_SUPPLY: REF_SOURCE = ARG_SRC_MAIN_SUPPLY; // R7
      REF_DIGITAL_SUPPLY: REF_SOURCE = ARG_SRC_DIGITAL_SUPPLY; // R7
      REF_HIGH_SPEED: REF_SOURCE = ARG_SRC_HIGH_SPEED; // R4
    endcase
  end

  // Ground source; internal overrides take priority over the pin select
  always_comb
  begin
    if (st_ff.phase == ARG_SAMPLE && st_ff.act_sensor)
      GND_SOURCE = ARG_GND_INTERNAL; // R9
    else if (st_ff.phase == ARG_CONVERT &&
             st_ff.act_ref_sel == REF_HIGH_SPEED)
      GND_SOURCE = ARG_GND_INTERNAL; // R10
    else if (st_ff.act_gnd_sel)
      GND_SOURCE = ARG_GND_ANALOG_PIN; // R8
    else
      GND_SOURCE = ARG_GND_PIN; // R8
  end

  // High-speed reference wakes only while a conversion cycle runs
  assign HS_REF_ENABLE = (st_ff.act_ref_sel == REF_HIGH_SPEED) &&
                         (st_ff.phase != ARG_IDLE); // R4 R5
  // Precision reference follows the output enable bit directly
  assign PRECISION_REF_ENABLE = st_ff.ref_oe; // R6
  assign EXTERNAL_REF_PIN_DRIVE = st_ff.ref_oe &&
                                  (st_ff.ref_sel == REF_EXTERNAL); // R6
  assign TEMP_SENSOR_ENABLE = st_ff.temp_en; // R11
  assign TEMP_SENSOR_HIZ = !st_ff.temp_en; // R11

  // Checks share the system clock and the synchronised reset
  default clocking chk_cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!rst_n);

  chk_hs_idle_off: assert property ( // R5
    st_ff.phase == ARG_IDLE |-> !HS_REF_ENABLE)
    else $error("high-speed reference on while idle");
  chk_hs_on_sel: assert property ( // R4
    (st_ff.phase == ARG_CONVERT && st_ff.act_ref_sel == REF_HIGH_SPEED)
      |-> HS_REF_ENABLE && REF_SOURCE == ARG_SRC_HIGH_SPEED)
    else $error("high-speed reference not enabled in conversion");
  chk_off_high: assert property ( // R1
    SFR_ADDR == TEMP_OFFSET_HIGH_ADDR |-> SFR_RDATA == TEMP_OFFSET_VALUE[9:2])
    else $error("offset high byte wrong");
  chk_off_low: assert property ( // R2
    SFR_ADDR == TEMP_OFFSET_LOW_ADDR
      |-> SFR_RDATA == {TEMP_OFFSET_VALUE[1:0], 6'h00})
    else $error("offset low byte wrong");
  chk_prec_pin: assert property ( // R6
    (ctrl_wr && CLK_EN && SFR_WDATA[REF_OE_BIT] &&
     SFR_WDATA[REF_SEL_HI:REF_SEL_LO] == REF_EXTERNAL)
      |=> EXTERNAL_REF_PIN_DRIVE && PRECISION_REF_ENABLE)
    else $error("precision reference not driven to pin");
  chk_supply_sel: assert property ( // R7
    st_ff.act_ref_sel == REF_DIGITAL_SUPPLY
      |-> REF_SOURCE == ARG_SRC_DIGITAL_SUPPLY)
    else $error("digital supply reference not selected");
  // Ground pin choice must follow the select bit held at sample entry
  chk_gnd_pin: assert property ( // R8
    (CLK_EN && SAMPLE_ACTIVE && !SENSOR_CHANNEL && st_ff.phase == ARG_IDLE)
      |=> GND_SOURCE ==
        ($past(st_ff.gnd_sel) ? ARG_GND_ANALOG_PIN : ARG_GND_PIN))
    else $error("ground pin select wrong");
  chk_sensor_gnd: assert property ( // R9
    (st_ff.phase == ARG_SAMPLE && st_ff.act_sensor)
      |-> GND_SOURCE == ARG_GND_INTERNAL)
    else $error("sensor sample not on internal ground");
  chk_hs_gnd: assert property ( // R10
    (st_ff.phase == ARG_CONVERT && st_ff.act_ref_sel == REF_HIGH_SPEED)
      |-> GND_SOURCE == ARG_GND_INTERNAL)
    else $error("high-speed conversion not on internal ground");
  chk_sensor_hiz: assert property ( // R11
    (ctrl_wr && CLK_EN && !SFR_WDATA[TEMP_EN_BIT]) |=> TEMP_SENSOR_HIZ)
    else $error("sensor not high impedance when disabled");
  chk_ctrl_read: assert property ( // R13
    SFR_ADDR == REFERENCE_CONTROL_ADDR |-> SFR_RDATA[7:6] == 2'h0 &&
      !SFR_RDATA[1])
    else $error("unused control bits not zero");
  chk_hold_conv: assert property ( // R14
    (st_ff.phase == ARG_CONVERT && $past(st_ff.phase) == ARG_CONVERT)
      |-> $stable(st_ff.act_ref_sel))
    else $error("reference changed during conversion");
endmodule : arg_ref_select

// >>> testbench/test_arg_ref_select.sv
// Self-checking bench for the reference and ground select block
`timescale 1ns/1ps
module test_arg_ref_select;
  import arg_pkg::*;
  // Stimulus driven shortly after each rising edge
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [9:0] trim = 10'h000;
  logic sample = 1'b0;
  logic convert = 1'b0;
  logic sensor = 1'b0;
  // Observed outputs
  logic [7:0] sfr_rdata;
  arg_ref_src_t ref_source;
  arg_gnd_src_t gnd_source;
  logic hs_en, prec_en, pin_drive, ts_en, ts_hiz;
  // Scoreboard state; the mask hides fields left open while idle
  int n_fail = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h11;
  logic [17:0] exp_q[$];
  logic [17:0] msk_q[$];
  event look;

  always #25 sys_clk = ~sys_clk;

  arg_ref_select arg_ref_select_i (.SYS_CLK(sys_clk), .RSTN(rstn),
    .CLK_EN(clk_en), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr),
    .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata),
    .TEMP_OFFSET_VALUE(trim), .SAMPLE_ACTIVE(sample),
    .CONVERT_ACTIVE(convert), .SENSOR_CHANNEL(sensor),
    .REF_SOURCE(ref_source), .GND_SOURCE(gnd_source),
    .HS_REF_ENABLE(hs_en), .PRECISION_REF_ENABLE(prec_en),
    .EXTERNAL_REF_PIN_DRIVE(pin_drive), .TEMP_SENSOR_ENABLE(ts_en),
    .TEMP_SENSOR_HIZ(ts_hiz));

  // Fixed-seed xorshift source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Expected outputs; sources follow the setting latched at sample start
  function automatic logic [17:0] model(input logic [7:0] live,
    input logic [7:0] lat, input arg_phase_t ph, input logic sens);
    arg_ref_src_t r;
    arg_gnd_src_t g;
    case (lat[4:3])
      2'h0: r = lat[0] ? ARG_SRC_PRECISION : ARG_SRC_EXT_PIN;
      2'h1: r = ARG_SRC_MAIN_SUPPLY;
      2'h2: r = ARG_SRC_DIGITAL_SUPPLY;
      default: r = ARG_SRC_HIGH_SPEED;
    endcase
    g = lat[5] ? ARG_GND_ANALOG_PIN : ARG_GND_PIN;
    if (ph == ARG_SAMPLE && sens) g = ARG_GND_INTERNAL;
    if (ph == ARG_CONVERT && lat[4:3] == 2'h3) g = ARG_GND_INTERNAL;
    return {live, r, g, lat[4:3] == 2'h3 && ph != ARG_IDLE, live[0],
      live[0] && live[4:3] == 2'h0, live[2], !live[2]};
  endfunction : model

  task automatic tick();
    @(posedge sys_clk);
    #2;
  endtask : tick

  // Note a result, then let the watcher compare it once inputs settle
  task automatic check(input logic [17:0] e, input logic [17:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    #1;
    ->look;
    #1; // Watcher samples before the caller moves any input
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick();
    sfr_wr = 1'b0;
    sfr_addr = REFERENCE_CONTROL_ADDR;
  endtask : wr

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // Watcher takes the oldest note and compares the unmasked fields
  always @(look)
  begin : watch
    logic [17:0] e, m, g;
    e = exp_q.pop_front();
    m = msk_q.pop_front();
    g = {sfr_rdata, ref_source, gnd_source, hs_en, prec_en, pin_drive,
      ts_en, ts_hiz};
    check_count++;
    if (((g ^ e) & m) !== 18'h0)
    begin
      n_fail++;
      $display("[ERR] %0t exp %h got %h", $time, e & m, g & m);
    end
  end

  // Hang guard; the run needs about a hundred cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    final_report();
  end

  initial
  begin : main
    logic [7:0] c;
    repeat (6) tick();
    rstn = 1'b1;
    repeat (3) tick();
    sfr_addr = REFERENCE_CONTROL_ADDR;
    check(model(8'h18, 8'h18, ARG_IDLE, 1'b0), 18'h3ffff);
    $display("test reset done");
    repeat (4)
    begin
      trim = 10'(xs());
      wr(TEMP_OFFSET_LOW_ADDR, 8'hff);
      sfr_addr = TEMP_OFFSET_HIGH_ADDR;
      check({trim[9:2], 10'h000}, 18'h3fc00);
      sfr_addr = TEMP_OFFSET_LOW_ADDR;
      check({trim[1:0], 16'h0000}, 18'h3fc00);
    end
    sfr_addr = 8'h40;
    check(18'h00000, 18'h3fc00);
    $display("test offset done");
    repeat (4)
    begin
      c = 8'(xs());
      wr(REFERENCE_CONTROL_ADDR, c);
      check(model(c & 8'h3d, 8'h00, ARG_IDLE, 1'b0), 18'h3fc1f);
    end
    // Frozen clock enable must drop the write
    clk_en = 1'b0;
    wr(REFERENCE_CONTROL_ADDR, ~c);
    clk_en = 1'b1;
    check(model(c & 8'h3d, 8'h00, ARG_IDLE, 1'b0), 18'h3fc1f);
    // External reference setup, then precision enabled from select 00
    wr(REFERENCE_CONTROL_ADDR, 8'h00);
    sample = 1'b1;
    tick();
    check(model(8'h00, 8'h00, ARG_SAMPLE, 1'b0), 18'h3ffff);
    sample = 1'b0;
    wr(REFERENCE_CONTROL_ADDR, 8'h01);
    check(model(8'h01, 8'h00, ARG_IDLE, 1'b0), 18'h3fc1f);
    $display("test register done");
    for (int i = 0; i < 16; i++)
    begin
      c = 8'(xs()) & 8'h05;
      c = c | {2'b00, i[2], i[1:0], 3'h0};
      wr(REFERENCE_CONTROL_ADDR, c);
      sensor = i[3];
      sample = 1'b1;
      tick();
      check(model(c, c, ARG_SAMPLE, i[3]), 18'h3ffff);
      sample = 1'b0;
      convert = 1'b1;
      tick();
      check(model(c, c, ARG_CONVERT, i[3]), 18'h3ffff);
      wr(REFERENCE_CONTROL_ADDR, c ^ 8'h18);
      check(model(c ^ 8'h18, c, ARG_CONVERT, i[3]), 18'h3ffff);
      convert = 1'b0;
      tick();
      check(model(c ^ 8'h18, c, ARG_IDLE, i[3]), 18'h3fc1f);
    end
    $display("test phases done");
    final_report();
  end
endmodule : test_arg_ref_select
